// ==== smip_pkg.sv ====
// Constants for the SMI and wake status/enable bank: register indexes, masks, resets.
// Assumes an APB master with 32-bit data; byte address is four times the register index.
//
// Functional notes
// - Wake output asserts only with global wake enable 1 and either enable and status both 1, or group SMI routed to wake.
// - Disabled wake source still records status but never drives the wake output.
// - Wake enable group five bits 0..7 map to group five pins 0..7.
// - Wake enable group five clears only on standby reset, not other resets.
// - Reserved indexes 0F and 15 read zero and ignore writes.
// - Peripheral SMI status follows sources; host writes never clear it.
// - Parallel bit reads 1 while port inactive, else follows acknowledge input.
// - Peripheral status defaults 02; parallel bit forced 1 on any reset.
// - Peripheral status bits 2..5: second UART, first UART, floppy, MIDI.
// - Input-device status mouse, keyboard, port1 line2 bits clear only at source.
// - Infrared bit sets on selected receive input transition, cleared by read.
// - Pin status registers clear bits written with one, keep bits written zero.
// - Pins A status: bits 0-2 pins 20-22, 4-6 pins 24-26, 7 pin 60.
// - Pins B status: bits 0-3 pins 30-33, 4-7 pins 41,42,43,61.
// - Fan status: bits 0-3 pins 54-57, bit 6 first fan, bit 7 second.
// - Peripheral SMI enable bits 1..5 gate their sources onto group SMI.
// - Status two to five and peripheral enable reset to 00 on standby reset.
// - Group SMI routes to pin, serial stream and wake, each separately enabled.
package smip_pkg;

    // ----------------------------------------------------------------
    // Register indexes
    // ----------------------------------------------------------------
    localparam logic [9:0] IDX_WAKE_EN5   = 10'h00E;
    localparam logic [9:0] IDX_RSVD_A     = 10'h00F;
    localparam logic [9:0] IDX_STS_PERIPH = 10'h010;
    localparam logic [9:0] IDX_STS_INPUT  = 10'h011;
    localparam logic [9:0] IDX_STS_PINS_A = 10'h012;
    localparam logic [9:0] IDX_STS_PINS_B = 10'h013;
    localparam logic [9:0] IDX_STS_FANS   = 10'h014;
    localparam logic [9:0] IDX_RSVD_B     = 10'h015;
    localparam logic [9:0] IDX_EN_PERIPH  = 10'h016;
    localparam logic [9:0] IDX_EN_INPUT   = 10'h017;
    localparam logic [9:0] IDX_EN_PINS_A  = 10'h018;
    localparam logic [9:0] IDX_EN_PINS_B  = 10'h019;
    localparam logic [9:0] IDX_EN_FANS    = 10'h01A;
    localparam logic [9:0] IDX_CONTROL    = 10'h020;
    localparam logic [9:0] IDX_WAKE_STS5  = 10'h021;
    localparam logic [9:0] IDX_IRQ_STS    = 10'h022;
    localparam logic [9:0] IDX_IRQ_MASK   = 10'h023;

    // ----------------------------------------------------------------
    // Reset values and writable masks
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_ZERO        = 8'h00;
    localparam logic [7:0] RST_STS_PERIPH  = 8'h02;
    localparam logic [7:0] MASK_EN_PERIPH  = 8'h3E;
    localparam logic [7:0] MASK_EN_INPUT   = 8'hF7;
    localparam logic [7:0] MASK_EN_PINS_A  = 8'hF7;
    localparam logic [7:0] MASK_EN_FANS    = 8'hCF;
    localparam logic [7:0] MASK_CONTROL    = 8'h07;
    localparam logic [7:0] MASK_IRQ        = 8'h03;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTL_GLOBAL_WAKE  = 0;
    localparam int CTL_PAR_ACTIVE   = 1;
    localparam int CTL_IR_SELECT_B  = 2;
    localparam int ROUTE_WAKE       = 5;
    localparam int ROUTE_SERIAL     = 6;
    localparam int ROUTE_PIN        = 7;
    localparam int IRQ_SMI_RISE     = 0;
    localparam int IRQ_WAKE_RISE    = 1;

    // Width of the synchronised pin vector
    localparam int SYNC_W = 31;

endpackage : smip_pkg

// ==== smip_sync.sv ====
// Three-stage pin synchroniser with an agreement filter.
// Assumes inputs are asynchronous to clk; outputs are in the clk domain.
`timescale 1ns/100ps
module smip_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rstn,
    // Pins and filtered view
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] level,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] change
);
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;
    logic [W-1:0] agree;
    logic [W-1:0] next_level;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ff1 <= '0;
            ff2 <= '0;
            ff3 <= '0;
        end else begin
            ff1 <= din;
            ff2 <= ff1;
            ff3 <= ff2;
        end
    end

    // A level only counts once stages two and three match
    assign agree      = ~(ff2 ^ ff3);
    assign next_level = (ff3 & agree) | (level & ~agree);
    assign change     = next_level ^ level;
    assign rise       = next_level & ~level;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            level <= '0;
        end else begin
            level <= next_level;
        end
    end

endmodule : smip_sync

// ==== smip_w1c_bank.sv ====
// Sticky status bits: hardware sets, software clears by writing one.
// Assumes set and clear are single-cycle strobes on the same clock.
`timescale 1ns/100ps
module smip_w1c_bank #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rstn,
    // Set and clear strobes
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clr,
    // State
    output logic      [W-1:0] flags
);
    // Set wins so an event landing on the clear cycle is kept
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flags <= '0;
        end else begin
            flags <= set | (flags & ~clr);
        end
    end

endmodule : smip_w1c_bank

// ==== smip_bank.sv ====
// SMI status/enable and group-five wake bank behind an APB slave.
// Assumes presetn is the standby-power reset and other resets arrive as a pulse.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/100ps
module smip_bank (
    // Clock and standby reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Main-power, soft and hard resets, combined pulse
    input  wire logic        system_reset,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Peripheral interrupt levels, same clock
    input  wire logic        second_uart_irq,
    input  wire logic        first_uart_irq,
    input  wire logic        floppy_irq,
    input  wire logic        midi_irq,
    input  wire logic        mouse_irq,
    input  wire logic        keyboard_irq,
    input  wire logic        port1_line2_irq,
    // Pins
    input  wire logic        printer_acknowledge_n,
    input  wire logic        infrared_receive_a,
    input  wire logic        infrared_receive_b,
    input  wire logic        fan_speed_input_first,
    input  wire logic        fan_speed_input_second,
    input  wire logic [7:0]  general_pin_group2,
    input  wire logic [3:0]  general_pin_group3,
    input  wire logic [3:0]  general_pin_group4,
    input  wire logic [7:0]  general_pin_group5,
    input  wire logic [1:0]  general_pin_group6,
    // Outputs
    output logic             wake_out_n,
    output logic             group_smi_n,
    output logic             smi_serial_request,
    output logic             irq
);
    import smip_pkg::*;

    // ----------------------------------------------------------------
    // Pin synchronisation
    // ----------------------------------------------------------------
    logic [SYNC_W-1:0] pins_raw;
    logic [SYNC_W-1:0] pins_level;
    logic [SYNC_W-1:0] pins_rise;
    logic [SYNC_W-1:0] pins_change;
    logic [7:0]        gp2_rise;
    logic [3:0]        gp3_rise;
    logic [3:0]        gp4_rise;
    logic [7:0]        gp5_rise;
    logic [1:0]        gp6_rise;
    logic [1:0]        fan_rise;
    logic              ack_rise;
    logic [1:0]        ir_rise;
    logic              ack_level;

    assign pins_raw = {general_pin_group2, general_pin_group3, general_pin_group4,
                       general_pin_group5, general_pin_group6, fan_speed_input_second,
                       fan_speed_input_first, printer_acknowledge_n,
                       infrared_receive_b, infrared_receive_a};

    smip_sync #(.W(SYNC_W)) u_sync (
        .clk    (pclk),
        .rstn   (presetn),
        .din    (pins_raw),
        .level  (pins_level),
        .rise   (pins_rise),
        .change (pins_change)
    );

    assign {gp2_rise, gp3_rise, gp4_rise, gp5_rise, gp6_rise, fan_rise,
            ack_rise, ir_rise} = pins_rise;
    assign ack_level = pins_level[2];

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    logic [9:0] idx;
    logic       aligned;
    logic       access;
    logic       wr;
    logic       rd_done;
    logic [7:0] wdat;
    logic       mapped;

    assign idx     = paddr[11:2];
    assign aligned = (paddr[1:0] == 2'b00);
    assign access  = psel & penable & pready;
    assign wr      = access & pwrite & pstrb[0] & aligned;
    assign rd_done = access & ~pwrite & aligned;
    assign wdat    = pwdata[7:0];

    assign mapped = aligned && (idx inside {IDX_WAKE_EN5, IDX_RSVD_A, IDX_STS_PERIPH,
                    IDX_STS_INPUT, IDX_STS_PINS_A, IDX_STS_PINS_B, IDX_STS_FANS, IDX_RSVD_B,
                    IDX_EN_PERIPH, IDX_EN_INPUT, IDX_EN_PINS_A, IDX_EN_PINS_B, IDX_EN_FANS,
                    IDX_CONTROL, IDX_WAKE_STS5, IDX_IRQ_STS, IDX_IRQ_MASK});

    // ----------------------------------------------------------------
    // Writable registers
    // ----------------------------------------------------------------
    logic [7:0] wake_enable_group5;
    logic [7:0] smi_enable_peripherals;
    logic [7:0] smi_enable_input_devices;
    logic [7:0] smi_enable_pins_a;
    logic [7:0] smi_enable_pins_b;
    logic [7:0] smi_enable_pins_fans;
    logic [7:0] control;
    logic [7:0] irq_mask;

    // Only the standby reset reaches these; system_reset is ignored here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_enable_group5 <= RST_ZERO;
        end else if (wr && idx == IDX_WAKE_EN5) begin
            wake_enable_group5 <= wdat;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            smi_enable_peripherals   <= RST_ZERO;
            smi_enable_input_devices <= RST_ZERO;
            smi_enable_pins_a        <= RST_ZERO;
            smi_enable_pins_b        <= RST_ZERO;
            smi_enable_pins_fans     <= RST_ZERO;
        end else if (wr) begin
            case (idx)
                IDX_EN_PERIPH: smi_enable_peripherals   <= wdat & MASK_EN_PERIPH;
                IDX_EN_INPUT:  smi_enable_input_devices <= wdat & MASK_EN_INPUT;
                IDX_EN_PINS_A: smi_enable_pins_a        <= wdat & MASK_EN_PINS_A;
                IDX_EN_PINS_B: smi_enable_pins_b        <= wdat;
                IDX_EN_FANS:   smi_enable_pins_fans     <= wdat & MASK_EN_FANS;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control  <= RST_ZERO;
            irq_mask <= RST_ZERO;
        end else if (wr && idx == IDX_CONTROL) begin
            control <= wdat & MASK_CONTROL;
        end else if (wr && idx == IDX_IRQ_MASK) begin
            irq_mask <= wdat & MASK_IRQ;
        end
    end

    // ----------------------------------------------------------------
    // Source-cleared and read-cleared status
    // ----------------------------------------------------------------
    logic [7:0] smi_status_peripherals;
    logic [7:0] input_levels;
    logic       infrared_edge_flag;
    logic       ir_edge;
    logic       ir_read_clear;
    logic [7:0] smi_status_input_devices;

    // Any reset forces the parallel bit; inactive port reads 1
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            smi_status_peripherals <= RST_STS_PERIPH;
        end else begin
            smi_status_peripherals <= {2'b00, midi_irq, floppy_irq, first_uart_irq,
                                       second_uart_irq, 1'b0, 1'b0};
            smi_status_peripherals[1] <= system_reset | ~control[CTL_PAR_ACTIVE]
                                         | ack_level;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            input_levels <= RST_ZERO;
        end else begin
            input_levels <= {3'b000, port1_line2_irq, 1'b0, 1'b0, keyboard_irq,
                             mouse_irq};
        end
    end

    // Edge taken before the receive mux; changing the select makes no edge
    assign ir_edge       = control[CTL_IR_SELECT_B] ? pins_change[1] : pins_change[0];
    assign ir_read_clear = rd_done && idx == IDX_STS_INPUT;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            infrared_edge_flag <= 1'b0;
        end else begin
            infrared_edge_flag <= ir_edge | (infrared_edge_flag & ~ir_read_clear);
        end
    end

    always_comb begin
        smi_status_input_devices    = input_levels;
        smi_status_input_devices[2] = infrared_edge_flag;
    end

    // ----------------------------------------------------------------
    // Write-one-to-clear status
    // ----------------------------------------------------------------
    logic [7:0] smi_status_pins_a;
    logic [7:0] smi_status_pins_b;
    logic [7:0] smi_status_pins_fans;
    logic [7:0] wake_status_group5;
    logic [7:0] irq_status;
    logic [7:0] set_a;
    logic [7:0] set_b;
    logic [7:0] set_fans;
    logic [7:0] irq_set;

    assign set_a    = {gp6_rise[0], gp2_rise[6:4], 1'b0, gp2_rise[2:0]};
    assign set_b    = {gp6_rise[1], gp4_rise[3:1], gp3_rise};
    assign set_fans = {fan_rise[1], fan_rise[0], 2'b00, gp5_rise[7:4]};

    smip_w1c_bank #(.W(8)) u_sts_a (
        .clk   (pclk),
        .rstn  (presetn),
        .set   (set_a),
        .clr   ((wr && idx == IDX_STS_PINS_A) ? wdat : RST_ZERO),
        .flags (smi_status_pins_a)
    );

    smip_w1c_bank #(.W(8)) u_sts_b (
        .clk   (pclk),
        .rstn  (presetn),
        .set   (set_b),
        .clr   ((wr && idx == IDX_STS_PINS_B) ? wdat : RST_ZERO),
        .flags (smi_status_pins_b)
    );

    smip_w1c_bank #(.W(8)) u_sts_fans (
        .clk   (pclk),
        .rstn  (presetn),
        .set   (set_fans),
        .clr   ((wr && idx == IDX_STS_FANS) ? wdat : RST_ZERO),
        .flags (smi_status_pins_fans)
    );

    // Status keeps recording even with wake disabled
    smip_w1c_bank #(.W(8)) u_wake_sts (
        .clk   (pclk),
        .rstn  (presetn),
        .set   (gp5_rise),
        .clr   ((wr && idx == IDX_WAKE_STS5) ? wdat : RST_ZERO),
        .flags (wake_status_group5)
    );

    smip_w1c_bank #(.W(8)) u_irq_sts (
        .clk   (pclk),
        .rstn  (presetn),
        .set   (irq_set),
        .clr   ((wr && idx == IDX_IRQ_STS) ? (wdat & MASK_IRQ) : RST_ZERO),
        .flags (irq_status)
    );

    // ----------------------------------------------------------------
    // Group SMI and wake
    // ----------------------------------------------------------------
    logic smi_any;
    logic wake_any;
    logic smi_prev;
    logic wake_prev;

    assign smi_any = |(smi_status_peripherals & smi_enable_peripherals)
                   | |(smi_status_input_devices & smi_enable_input_devices & MASK_EN_PINS_A)
                   | |(smi_status_pins_a & smi_enable_pins_a)
                   | |(smi_status_pins_b & smi_enable_pins_b)
                   | |(smi_status_pins_fans & smi_enable_pins_fans);

    assign wake_any = control[CTL_GLOBAL_WAKE]
                    & ( |(wake_enable_group5 & wake_status_group5)
                      | (smi_any & smi_enable_input_devices[ROUTE_WAKE]));

    assign irq_set = {6'b000000, wake_any & ~wake_prev, smi_any & ~smi_prev};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            group_smi_n        <= 1'b1;
            smi_serial_request <= 1'b0;
            wake_out_n         <= 1'b1;
            smi_prev           <= 1'b0;
            wake_prev          <= 1'b0;
        end else begin
            group_smi_n        <= ~(smi_any & smi_enable_input_devices[ROUTE_PIN]);
            smi_serial_request <= smi_any & smi_enable_input_devices[ROUTE_SERIAL];
            wake_out_n         <= ~wake_any;
            smi_prev           <= smi_any;
            wake_prev          <= wake_any;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_mask);
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    logic [7:0] rd_mux;

    always_comb begin
        rd_mux = RST_ZERO;
        case (idx)
            IDX_WAKE_EN5:   rd_mux = wake_enable_group5;
            IDX_STS_PERIPH: rd_mux = smi_status_peripherals;
            IDX_STS_INPUT:  rd_mux = smi_status_input_devices;
            IDX_STS_PINS_A: rd_mux = smi_status_pins_a;
            IDX_STS_PINS_B: rd_mux = smi_status_pins_b;
            IDX_STS_FANS:   rd_mux = smi_status_pins_fans;
            IDX_EN_PERIPH:  rd_mux = smi_enable_peripherals;
            IDX_EN_INPUT:   rd_mux = smi_enable_input_devices;
            IDX_EN_PINS_A:  rd_mux = smi_enable_pins_a;
            IDX_EN_PINS_B:  rd_mux = smi_enable_pins_b;
            IDX_EN_FANS:    rd_mux = smi_enable_pins_fans;
            IDX_CONTROL:    rd_mux = control;
            IDX_WAKE_STS5:  rd_mux = wake_status_group5;
            IDX_IRQ_STS:    rd_mux = irq_status;
            IDX_IRQ_MASK:   rd_mux = irq_mask;
            default:        rd_mux = RST_ZERO;
        endcase
    end

    // One wait state: data and pready are registered together
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (psel && penable && !pready) begin
            pready  <= 1'b1;
            pslverr <= ~mapped;
            prdata  <= (mapped && !pwrite) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
    end

endmodule : smip_bank

// ==== smip_bank_sva.sv ====
// Checker: APB answer timing and reserved read-back of the bank.
// Assumes it is bound to smip_bank and sees its ports only.
`timescale 1ns/100ps
module smip_bank_sva (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr
);
    wire logic rd_done = psel && penable && pready && !pwrite;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup; psel && !penable; endsequence
    sequence s_access; psel && penable; endsequence
    property p_ready_lat; s_setup ##1 s_access |=> pready; endproperty
    property p_ready_pulse; pready |=> !pready; endproperty
    property p_idle_quiet; !(psel && penable) |=> !pready; endproperty
    property p_err_ready; pslverr |-> pready && prdata == 32'h0; endproperty
    property p_unaligned; psel && penable && pready && paddr[1:0] != 2'h0 |-> pslverr;
    endproperty
    property p_rsvd_zero; rd_done && (paddr == 12'h03C || paddr == 12'h054) |-> prdata == 0;
    endproperty
    property p_rsvd_ok; rd_done && (paddr == 12'h03C || paddr == 12'h054) |-> !pslverr;
    endproperty
    property p_upper_zero; pready |-> prdata[31:8] == 24'h0; endproperty
    a_ready_lat: assert property (p_ready_lat) else $error("pready late");
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
    a_idle_quiet: assert property (p_idle_quiet) else $error("pready without access");
    a_err_ready: assert property (p_err_ready) else $error("pslverr misplaced");
    a_unaligned: assert property (p_unaligned) else $error("unaligned accepted");
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved not zero");
    a_rsvd_ok: assert property (p_rsvd_ok) else $error("reserved read refused");
    a_upper_zero: assert property (p_upper_zero) else $error("upper data set");
endmodule : smip_bank_sva
bind smip_bank smip_bank_sva chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .prdata, .pready, .pslverr);

// ==== smip_host.sv ====
// Host model: APB master issuing register reads and writes.
// Assumes tb_top holds n_mismatch and finish_test for a hung bus.
`timescale 1ns/100ps
module smip_host (
    // Clock
    input  wire logic        pclk,
    // APB request
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata,
    output logic      [3:0]  pstrb,
    // APB answer
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial {psel, penable, pwrite, paddr, pwdata, pstrb} = {15'h0, 32'h0, 4'hF};
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        int n;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            tb_top.n_mismatch++;
            tb_top.finish_test();
        end
        q = prdata;
        e = pslverr;
        // Idle data inverted so a stale word is never mistaken for a fresh one
        {psel, penable, pwdata} <= {2'b00, ~d};
    endtask : xfer
endmodule : smip_host

// ==== tb_top.sv ====
// Bench: register map, clearing, wake and SMI outputs, interrupt.
// Assumes smip_host as the APB master and the checker bound to the bank.
`timescale 1ns/100ps
module tb_top;
    import smip_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn, system_reset, psel, penable, pwrite, pready, pslverr, e;
    logic        wake_out_n, group_smi_n, smi_serial_request, irq;
    logic        second_uart_irq, first_uart_irq, floppy_irq, midi_irq;
    logic        mouse_irq, keyboard_irq, port1_line2_irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0]  pstrb;
    logic [30:0] pins;
    logic [7:0]  w;
    logic [9:0]  sidx [3] = '{IDX_STS_PINS_A, IDX_STS_PINS_B, IDX_STS_FANS};
    logic [7:0]  sfull [3] = '{8'hF7, 8'hFF, 8'hCF};
    int          n_mismatch = 0, n_checks = 0, seed = 32'heddf, j;
    smip_host host_u (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
        .pready, .pslverr);
    smip_bank dut_u (.pclk, .presetn, .system_reset, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .second_uart_irq, .first_uart_irq,
        .floppy_irq, .midi_irq, .mouse_irq, .keyboard_irq, .port1_line2_irq,
        .printer_acknowledge_n(pins[0]), .infrared_receive_a(pins[1]),
        .infrared_receive_b(pins[2]), .fan_speed_input_first(pins[3]),
        .fan_speed_input_second(pins[4]), .general_pin_group2(pins[12:5]),
        .general_pin_group3(pins[16:13]), .general_pin_group4(pins[20:17]),
        .general_pin_group5(pins[28:21]), .general_pin_group6(pins[30:29]),
        .wake_out_n, .group_smi_n, .smi_serial_request, .irq);
    function automatic logic [7:0] w1c(input logic [7:0] o, x); return o & ~x; endfunction : w1c
    function automatic logic [7:0] sts_per(input logic p);
        return {2'h0, midi_irq, floppy_irq, first_uart_irq, second_uart_irq, p, 1'b0};
    endfunction : sts_per
    function automatic logic [7:0] sts_in(input logic ir);
        return {3'h0, port1_line2_irq, 1'b0, ir, keyboard_irq, mouse_irq};
    endfunction : sts_in
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [9:0] i, input logic [7:0] d);
        host_u.xfer(1'b1, {i, 2'b00}, {24'h0, d}, q, e);
    endtask : wr
    task automatic rd(input logic [9:0] i, input logic [7:0] x, input string nm);
        host_u.xfer(1'b0, {i, 2'b00}, 32'h0, q, e);
        chk(nm, q, {24'h0, x});
    endtask : rd
    // Pin path needs four cycles through the filter, up to six to irq
    task automatic settle;
        repeat (8) @(posedge pclk);
    endtask : settle
    task automatic finish_test;
        if (n_mismatch == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    initial forever #2 pclk = ~pclk;
    initial begin
        presetn = 1'b0;
        system_reset = 1'b0;
        {second_uart_irq, first_uart_irq, floppy_irq, midi_irq} = 4'h0;
        {mouse_irq, keyboard_irq, port1_line2_irq} = 3'h0;
        pins = 31'h1;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 15; i < 18; i++) wr(10'(i), 8'hFF);
        wr(IDX_RSVD_B, 8'hFF);
        for (int i = 14; i < 23; i++) rd(10'(i), i == 16 ? 8'h02 : 8'h00, "rst");
        host_u.xfer(1'b0, 12'h0FC, 32'h0, q, e);
        chk("unmapped", {31'h0, e}, 32'h1);
        host_u.xfer(1'b0, 12'h041, 32'h0, q, e);
        chk("unaligned", {31'h0, e}, 32'h1);
        w = 8'($random(seed));
        wr(IDX_WAKE_EN5, w);
        system_reset <= 1'b1;
        @(posedge pclk);
        system_reset <= 1'b0;
        rd(IDX_WAKE_EN5, w, "en5_kept");
        {second_uart_irq, first_uart_irq, floppy_irq, midi_irq} <= 4'($random(seed));
        {mouse_irq, keyboard_irq, port1_line2_irq} <= 3'($random(seed));
        pins[0] <= 1'b0;
        settle();
        rd(IDX_STS_PERIPH, sts_per(1'b1), "per_idle");
        wr(IDX_CONTROL, 8'h02);
        rd(IDX_STS_PERIPH, sts_per(1'b0), "per_ack0");
        pins[0] <= 1'b1;
        pins[1] <= 1'b1;
        settle();
        rd(IDX_STS_PERIPH, sts_per(1'b1), "per_ack1");
        rd(IDX_STS_INPUT, sts_in(1'b1), "ir_set");
        rd(IDX_STS_INPUT, sts_in(1'b0), "ir_read_clr");
        j = {$random(seed)} % 8;
        wr(IDX_WAKE_EN5, ~(8'h01 << j));
        wr(IDX_CONTROL, 8'h03);
        pins[21 + j] <= 1'b1;
        settle();
        chk("wake_off", {31'h0, wake_out_n}, 32'h1);
        rd(IDX_WAKE_STS5, 8'h01 << j, "wake_sts");
        wr(IDX_WAKE_EN5, 8'h01 << j);
        settle();
        chk("wake_on", {31'h0, wake_out_n}, 32'h0);
        wr(IDX_CONTROL, 8'h02);
        settle();
        chk("wake_global", {31'h0, wake_out_n}, 32'h1);
        pins[30:3] <= '1;
        settle();
        for (int k = 0; k < 3; k++) begin
            rd(sidx[k], sfull[k], "pin_sts");
            w = 8'($random(seed));
            wr(sidx[k], w);
            rd(sidx[k], w1c(sfull[k], w), "pin_w1c");
        end
        wr(IDX_IRQ_MASK, 8'h03);
        wr(IDX_EN_PERIPH, 8'hFF);
        rd(IDX_EN_PERIPH, 8'h3E, "en_per");
        wr(IDX_EN_INPUT, 8'hC0);
        settle();
        chk("smi_pin", {31'h0, group_smi_n}, 32'h0);
        chk("smi_serial", {31'h0, smi_serial_request}, 32'h1);
        chk("irq_up", {31'h0, irq}, 32'h1);
        wr(IDX_IRQ_MASK, 8'h00);
        settle();
        chk("irq_masked", {31'h0, irq}, 32'h0);
        wr(IDX_IRQ_STS, 8'h03);
        rd(IDX_IRQ_STS, 8'h00, "irq_clr");
        wr(IDX_EN_PERIPH, 8'h00);
        settle();
        chk("smi_blocked", {31'h0, group_smi_n}, 32'h1);
        finish_test();
    end
endmodule : tb_top
